// ---- inc/link_params.svh ----
`ifndef LINK_PARAMS_SVH
`define LINK_PARAMS_SVH
// Clock and elementary time unit, both in ns.
`define CLK_NS 100
`define ETU_NS 400
`define ETU_CYC (`ETU_NS / `CLK_NS)
// Timing in etu.
`define CHAR_ETU 16'h000C
`define BGT_ETU 16'h0016
`define CWT_BASE_ETU 16'h000B
`define BWT_UNIT_ETU 16'h03C0
`define WTX_MARGIN_ETU 16'h0040
// Information field sizes.
`define IFS_DEF 8'h20
`define IFS_BAD 8'hFF
`define IFSC_VAL 8'h20
// Waiting indices announced by the card.
`define CWI_VAL 4'h5
`define BWI_VAL 4'h4
// Answer to reset: TS T0 TD1 TD2 TA3 TB3 TC3 TCK.
`define ATR_LAST 3'h7
`define ATR_TS 8'h3B
`define ATR_T0 8'h80
`define ATR_TD1 8'h81
`define ATR_TD2 8'h71
`define ATR_TC3 8'h00
`define ATR_TCK 8'h15
// Block prologue and control byte coding.
`define NAD_VAL 8'h00
`define PCB_R 8'h80
`define PCB_S 8'hC0
`define S_RESP 8'h20
`define S_RESYNC 6'h00
`define S_IFS 6'h01
`define S_WTX 6'h03
`define S_WTX_RESP 6'h23
`define WTX_MULT 8'h01
`define R_ERR_EDC 4'h1
`define R_ERR_OTHER 4'h2
// Protocol parameter selection.
`define PROT_BLOCK 4'h1
`define PPS_SS 8'hFF
`define PPS_P0 8'h01
`define PPS_CK 8'hFE
`define PPS_LAST 9'h002
`endif

// ---- inc/link_pkg.sv ----
package link_pkg;
  typedef enum logic [2:0] {
    C_ATR = 3'b000,
    C_RX = 3'b001,
    C_DECIDE = 3'b010,
    C_WAIT = 3'b011,
    C_GUARD = 3'b100,
    C_TX = 3'b101
  } card_state_t;
  typedef enum logic [2:0] {
    T_ATR = 3'b000,
    T_PPS_TX = 3'b001,
    T_PPS_RX = 3'b010,
    T_IDLE = 3'b011,
    T_TX = 3'b100,
    T_RX = 3'b101
  } term_state_t;
  typedef enum logic [1:0] {
    K_R = 2'b00,
    K_S = 2'b01,
    K_I = 2'b10
  } blk_kind_t;
endpackage

// ---- inc/card_link_if.sv ----
`timescale 1ns/1ps
// Character-level view of the shared I/O line: one strobe per character.
interface card_link_if;
  logic t2c_stb;
  logic [7:0] t2c_data;
  logic c2t_stb;
  logic [7:0] c2t_data;
  modport card (
    input t2c_stb,
    input t2c_data,
    output c2t_stb,
    output c2t_data
  );
  modport term (
    output t2c_stb,
    output t2c_data,
    input c2t_stb,
    input c2t_data
  );
endinterface

// ---- rtl/card_end.sv ----
// Contract
// R01: Reject received blocks longer than IFSC; the code checks only I-blocks.
// R02: IFSC is 32, announced in TA3.
// R03: Never send more than IFSD per I-block.
// R04: Chain long responses into IFSD-sized blocks.
// R05: Accept IFSD 254 and use it.
// R06: Refuse IFSD 255 with R-block error 2.
// R07: Large IFSD allows one or chained blocks.
// R08: TB3 waiting index lies from 0 to 5.
// R09: Character spacing stays below CWT.
// R10: Reply after BGT and before BWT.
// R11: Reply window exempts the WTX exchange.
// R12: Accept block 22 etu after last character.
// R13: Request WTX when nearing BWT.
// R14: Terminal selects protocol by PPS if needed.
// R15: TC3 is zero, longitudinal redundancy check.
// R16: Bad check answered by R-block error 1.
// R17: IFS response echoes the requested size.
// R18: CWT and BWT follow the waiting indices.
// R19: IFSD resets to default, changes on request.
`timescale 1ns/1ps
`include "link_params.svh"
module card_end #(
  parameter logic [15:0] BWT_ETU = 16'h3C0B
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Link toward the terminal.
  card_link_if.card link,
  // Command bytes toward the application.
  output logic cmd_stb,
  output logic [7:0] cmd_data,
  output logic cmd_end,
  output logic cmd_ok,
  // Response bytes from the application.
  input wire logic resp_avail,
  input wire logic [15:0] resp_len,
  input wire logic [7:0] resp_data,
  output logic resp_take,
  // Current terminal field size.
  output logic [7:0] ifsd
);
  logic [7:0] div_r, div_nxt;
  logic tick;
  link_pkg::card_state_t st_r, st_nxt;
  link_pkg::blk_kind_t kind_r, kind_nxt;
  logic [15:0] tmr_r, tmr_nxt, rem_r, rem_nxt, cwt;
  logic [8:0] pos_r, pos_nxt, rx_end_pos, tx_end_pos;
  logic [2:0] atr_r, atr_nxt;
  logic [7:0] pcb_r, pcb_nxt, len_r, len_nxt, inf0_r, inf0_nxt;
  logic [7:0] lrc_r, lrc_nxt, ifsd_r, ifsd_nxt;
  logic [7:0] tpcb_r, tpcb_nxt, tlen_r, tlen_nxt, tinf_r, tinf_nxt;
  logic bad_r, bad_nxt, ns_r, ns_nxt, nr_r, nr_nxt, big;
  logic c2t_stb_r, c2t_stb_nxt, cmd_stb_r, cmd_stb_nxt;
  logic [7:0] c2t_data_r, c2t_data_nxt, cmd_data_r, cmd_data_nxt;
  logic cmd_end_r, cmd_end_nxt, cmd_ok_r, cmd_ok_nxt;
  logic take_r, take_nxt;
  logic [7:0] tx_byte, atr_byte;

  function automatic logic [7:0] chunk(input logic [15:0] rem,
                                       input logic [7:0] lim);
    chunk = (rem > {8'h00, lim}) ? lim : rem[7:0];
  endfunction

  // Elementary time unit divider.
  always_comb begin
    div_nxt = tick ? 8'h00 : div_r + 8'h01;
  end
  assign tick = (div_r == 8'(`ETU_CYC - 1));
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_nxt;
    end
  end

  assign cwt = `CWT_BASE_ETU + (16'h0001 << `CWI_VAL); // R18
  assign rx_end_pos = 9'h003 + {1'b0, len_r};
  assign tx_end_pos = 9'h003 + {1'b0, tlen_r};
  assign big = (len_r > `IFSC_VAL); // R01

  // Answer to reset with TA3, TB3 and TC3 announced.
  always_comb begin
    case (atr_r)
      3'h0: atr_byte = `ATR_TS;
      3'h1: atr_byte = `ATR_T0;
      3'h2: atr_byte = `ATR_TD1;
      3'h3: atr_byte = `ATR_TD2;
      3'h4: atr_byte = `IFSC_VAL; // R02
      3'h5: atr_byte = {`BWI_VAL, `CWI_VAL}; // R08
      3'h6: atr_byte = `ATR_TC3; // R15
      default: atr_byte = `ATR_TCK;
    endcase
  end

  // Byte to send at the current position of an outgoing block.
  always_comb begin
    if (pos_r == 9'h000) begin
      tx_byte = `NAD_VAL;
    end else if (pos_r == 9'h001) begin
      tx_byte = tpcb_r;
    end else if (pos_r == 9'h002) begin
      tx_byte = tlen_r;
    end else if (pos_r < tx_end_pos) begin
      tx_byte = (kind_r == link_pkg::K_I) ? resp_data : tinf_r;
    end else begin
      tx_byte = lrc_r; // R15
    end
  end

  always_comb begin
    st_nxt = st_r;
    kind_nxt = kind_r;
    tmr_nxt = (tick && tmr_r != 16'hFFFF) ? tmr_r + 16'h0001 : tmr_r;
    rem_nxt = rem_r;
    pos_nxt = pos_r;
    atr_nxt = atr_r;
    pcb_nxt = pcb_r;
    len_nxt = len_r;
    inf0_nxt = inf0_r;
    lrc_nxt = lrc_r;
    ifsd_nxt = ifsd_r;
    tpcb_nxt = tpcb_r;
    tlen_nxt = tlen_r;
    tinf_nxt = tinf_r;
    bad_nxt = bad_r;
    ns_nxt = ns_r;
    nr_nxt = nr_r;
    c2t_stb_nxt = 1'b0;
    c2t_data_nxt = c2t_data_r;
    cmd_stb_nxt = 1'b0;
    cmd_data_nxt = cmd_data_r;
    cmd_end_nxt = 1'b0;
    cmd_ok_nxt = cmd_ok_r;
    take_nxt = 1'b0;
    case (st_r)
      link_pkg::C_ATR: begin
        if (tick && tmr_r >= `CHAR_ETU - 16'h0001) begin
          tmr_nxt = 16'h0000;
          c2t_stb_nxt = 1'b1;
          c2t_data_nxt = atr_byte;
          atr_nxt = atr_r + 3'h1;
          if (atr_r == `ATR_LAST) begin
            st_nxt = link_pkg::C_RX;
          end
        end
      end
      link_pkg::C_RX: begin
        if (link.t2c_stb) begin
          tmr_nxt = 16'h0000;
          pos_nxt = pos_r + 9'h001;
          lrc_nxt = (pos_r == 9'h000) ? link.t2c_data : lrc_r ^ link.t2c_data;
          if (pos_r == 9'h001) begin
            pcb_nxt = link.t2c_data;
          end
          if (pos_r == 9'h002) begin
            len_nxt = link.t2c_data;
          end
          if (pos_r >= 9'h003 && pos_r < rx_end_pos) begin
            if (pos_r == 9'h003) begin
              inf0_nxt = link.t2c_data;
            end
            if (!pcb_r[7]) begin
              cmd_stb_nxt = 1'b1;
              cmd_data_nxt = link.t2c_data;
            end
          end
          if (pos_r >= 9'h003 && pos_r == rx_end_pos) begin
            bad_nxt = ((lrc_r ^ link.t2c_data) != 8'h00);
            pos_nxt = 9'h000;
            st_nxt = link_pkg::C_DECIDE; // R12
          end
        end else if (pos_r != 9'h000 && tmr_r > cwt) begin
          pos_nxt = 9'h000;
        end
      end
      link_pkg::C_DECIDE: begin
        st_nxt = link_pkg::C_GUARD;
        kind_nxt = link_pkg::K_R;
        tlen_nxt = 8'h00;
        if (!pcb_r[7]) begin
          cmd_end_nxt = bad_r | big | ~pcb_r[5];
          cmd_ok_nxt = ~bad_r & ~big;
        end
        if (bad_r) begin
          tpcb_nxt = `PCB_R | {3'h0, nr_r, `R_ERR_EDC}; // R16
        end else if (!pcb_r[7]) begin
          if (big) begin
            tpcb_nxt = `PCB_R | {3'h0, nr_r, `R_ERR_OTHER}; // R01
          end else begin
            nr_nxt = ~nr_r;
            tpcb_nxt = `PCB_R | {3'h0, ~nr_r, 4'h0};
            if (!pcb_r[5]) begin
              st_nxt = link_pkg::C_WAIT;
            end
          end
        end else if (!pcb_r[6]) begin
          if (rem_r != 16'h0000) begin
            kind_nxt = link_pkg::K_I;
            tlen_nxt = chunk(rem_r, ifsd_r); // R04
            tpcb_nxt = {1'b0, ns_r, rem_r > {8'h00, ifsd_r}, 5'h00};
          end else begin
            st_nxt = link_pkg::C_RX;
          end
        end else begin
          case (pcb_r[5:0])
            `S_IFS: begin
              if (inf0_r == `IFS_BAD || inf0_r == 8'h00) begin
                tpcb_nxt = `PCB_R | {3'h0, nr_r, `R_ERR_OTHER}; // R06
              end else begin
                ifsd_nxt = inf0_r; // R05 R19
                kind_nxt = link_pkg::K_S;
                tpcb_nxt = `PCB_S | `S_RESP | {2'h0, `S_IFS};
                tlen_nxt = 8'h01;
                tinf_nxt = inf0_r; // R17
              end
            end
            `S_RESYNC: begin
              kind_nxt = link_pkg::K_S;
              tpcb_nxt = `PCB_S | `S_RESP | {2'h0, `S_RESYNC};
              ns_nxt = 1'b0;
              nr_nxt = 1'b0;
              rem_nxt = 16'h0000;
            end
            `S_WTX_RESP: begin
              st_nxt = link_pkg::C_WAIT; // R11
            end
            default: begin
              tpcb_nxt = `PCB_R | {3'h0, nr_r, `R_ERR_OTHER};
            end
          endcase
        end
      end
      link_pkg::C_WAIT: begin
        if (resp_avail) begin
          rem_nxt = resp_len;
          kind_nxt = link_pkg::K_I;
          tlen_nxt = chunk(resp_len, ifsd_r); // R03 R07
          tpcb_nxt = {1'b0, ns_r, resp_len > {8'h00, ifsd_r}, 5'h00}; // R04
          st_nxt = link_pkg::C_GUARD;
        end else if (tmr_r >= BWT_ETU - `WTX_MARGIN_ETU) begin
          kind_nxt = link_pkg::K_S;
          tpcb_nxt = `PCB_S | {2'h0, `S_WTX}; // R13
          tlen_nxt = 8'h01;
          tinf_nxt = `WTX_MULT;
          st_nxt = link_pkg::C_GUARD;
        end
      end
      link_pkg::C_GUARD: begin
        if (tmr_r > `BGT_ETU) begin
          st_nxt = link_pkg::C_TX; // R10
          pos_nxt = 9'h000;
          tmr_nxt = `CHAR_ETU;
        end
      end
      link_pkg::C_TX: begin
        if (tick && tmr_r >= `CHAR_ETU - 16'h0001) begin
          tmr_nxt = 16'h0000; // R09
          c2t_stb_nxt = 1'b1;
          c2t_data_nxt = tx_byte;
          lrc_nxt = (pos_r == 9'h000) ? tx_byte : lrc_r ^ tx_byte;
          pos_nxt = pos_r + 9'h001;
          if (kind_r == link_pkg::K_I && pos_r >= 9'h003 &&
              pos_r < tx_end_pos) begin
            take_nxt = 1'b1;
            rem_nxt = rem_r - 16'h0001;
          end
          if (pos_r == tx_end_pos) begin
            pos_nxt = 9'h000;
            st_nxt = link_pkg::C_RX;
            if (kind_r == link_pkg::K_I) begin
              ns_nxt = ~ns_r;
            end
          end
        end
      end
      default: begin
        st_nxt = link_pkg::C_RX;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= link_pkg::C_ATR;
      kind_r <= link_pkg::K_R;
      tmr_r <= `CHAR_ETU;
      rem_r <= 16'h0000;
      pos_r <= 9'h000;
      atr_r <= 3'h0;
      pcb_r <= 8'h00;
      len_r <= 8'h00;
      inf0_r <= 8'h00;
      lrc_r <= 8'h00;
      ifsd_r <= `IFS_DEF; // R19
      tpcb_r <= 8'h00;
      tlen_r <= 8'h00;
      tinf_r <= 8'h00;
      bad_r <= 1'b0;
      ns_r <= 1'b0;
      nr_r <= 1'b0;
      c2t_stb_r <= 1'b0;
      c2t_data_r <= 8'h00;
      cmd_stb_r <= 1'b0;
      cmd_data_r <= 8'h00;
      cmd_end_r <= 1'b0;
      cmd_ok_r <= 1'b0;
      take_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      kind_r <= kind_nxt;
      tmr_r <= tmr_nxt;
      rem_r <= rem_nxt;
      pos_r <= pos_nxt;
      atr_r <= atr_nxt;
      pcb_r <= pcb_nxt;
      len_r <= len_nxt;
      inf0_r <= inf0_nxt;
      lrc_r <= lrc_nxt;
      ifsd_r <= ifsd_nxt;
      tpcb_r <= tpcb_nxt;
      tlen_r <= tlen_nxt;
      tinf_r <= tinf_nxt;
      bad_r <= bad_nxt;
      ns_r <= ns_nxt;
      nr_r <= nr_nxt;
      c2t_stb_r <= c2t_stb_nxt;
      c2t_data_r <= c2t_data_nxt;
      cmd_stb_r <= cmd_stb_nxt;
      cmd_data_r <= cmd_data_nxt;
      cmd_end_r <= cmd_end_nxt;
      cmd_ok_r <= cmd_ok_nxt;
      take_r <= take_nxt;
    end
  end

  assign link.c2t_stb = c2t_stb_r;
  assign link.c2t_data = c2t_data_r;
  assign cmd_stb = cmd_stb_r;
  assign cmd_data = cmd_data_r;
  assign cmd_end = cmd_end_r;
  assign cmd_ok = cmd_ok_r;
  assign resp_take = take_r;
  assign ifsd = ifsd_r;
endmodule

// ---- rtl/term_end.sv ----
`timescale 1ns/1ps
`include "link_params.svh"
module term_end #(
  parameter logic [15:0] BWT_UNIT = `BWT_UNIT_ETU
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Link toward the card.
  card_link_if.term link,
  // Block bytes to send, prologue first, check byte appended here.
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready,
  // Received block bytes.
  output logic rx_stb,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic rx_ok,
  output logic rx_timeout,
  // Session parameters taken from the answer to reset.
  output logic [7:0] ifsc,
  output logic [3:0] cwi,
  output logic [3:0] bwi,
  output logic link_up
);
  logic [7:0] div_r, div_nxt;
  logic tick, sp_ok, done;
  link_pkg::term_state_t st_r, st_nxt;
  logic [15:0] tmr_r, tmr_nxt, cwt, bwt;
  logic [8:0] pos_r, pos_nxt;
  logic [7:0] len_r, len_nxt, lrc_r, lrc_nxt, ifsc_r, ifsc_nxt, d, pps;
  logic [3:0] y_r, y_nxt, k_r, k_nxt, prot_r, prot_nxt;
  logic [3:0] cwi_r, cwi_nxt, bwi_r, bwi_nxt;
  logic [1:0] lvl_r, lvl_nxt;
  logic tck_r, tck_nxt, last_r, last_nxt, rdy_r, rdy_nxt, up_r, up_nxt;
  logic t2c_stb_r, t2c_stb_nxt, rxs_r, rxs_nxt, rxe_r, rxe_nxt;
  logic ok_r, ok_nxt, to_r, to_nxt;
  logic [7:0] t2c_data_r, t2c_data_nxt, rxd_r, rxd_nxt;

  always_comb begin
    div_nxt = tick ? 8'h00 : div_r + 8'h01;
  end
  assign tick = (div_r == 8'(`ETU_CYC - 1));
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_nxt;
    end
  end

  assign cwt = `CWT_BASE_ETU + (16'h0001 << cwi_r); // R18
  assign bwt = `CWT_BASE_ETU + (BWT_UNIT << bwi_r); // R18
  assign d = link.c2t_data;
  assign sp_ok = tick && tmr_r >= `CHAR_ETU - 16'h0001;
  assign pps = (pos_r == 9'h000) ? `PPS_SS :
               (pos_r == 9'h001) ? `PPS_P0 : `PPS_CK;

  always_comb begin
    st_nxt = st_r;
    tmr_nxt = (tick && tmr_r != 16'hFFFF) ? tmr_r + 16'h0001 : tmr_r;
    pos_nxt = pos_r;
    len_nxt = len_r;
    lrc_nxt = lrc_r;
    ifsc_nxt = ifsc_r;
    y_nxt = y_r;
    k_nxt = k_r;
    prot_nxt = prot_r;
    cwi_nxt = cwi_r;
    bwi_nxt = bwi_r;
    lvl_nxt = lvl_r;
    tck_nxt = tck_r;
    last_nxt = last_r;
    rdy_nxt = 1'b0;
    up_nxt = up_r;
    t2c_stb_nxt = 1'b0;
    t2c_data_nxt = t2c_data_r;
    rxs_nxt = 1'b0;
    rxd_nxt = rxd_r;
    rxe_nxt = 1'b0;
    ok_nxt = ok_r;
    to_nxt = 1'b0;
    done = 1'b0;
    case (st_r)
      link_pkg::T_ATR: begin
        if (link.c2t_stb) begin
          tmr_nxt = 16'h0000;
          pos_nxt = pos_r + 9'h001;
          if (pos_r == 9'h001) begin
            y_nxt = d[7:4];
            k_nxt = d[3:0];
            lvl_nxt = 2'h1;
          end else if (pos_r == 9'h000) begin
            y_nxt = 4'h0;
          end else if (y_r[0]) begin
            y_nxt[0] = 1'b0;
            if (lvl_r == 2'h3) begin
              ifsc_nxt = d; // R02
            end
          end else if (y_r[1]) begin
            y_nxt[1] = 1'b0;
            if (lvl_r == 2'h3) begin
              cwi_nxt = d[3:0];
              bwi_nxt = d[7:4];
            end
          end else if (y_r[2]) begin
            y_nxt[2] = 1'b0;
          end else if (y_r[3]) begin
            y_nxt = d[7:4];
            tck_nxt = tck_r | (d[3:0] != 4'h0);
            if (lvl_r == 2'h1) begin
              prot_nxt = d[3:0];
            end
            if (lvl_r != 2'h3) begin
              lvl_nxt = lvl_r + 2'h1;
            end
          end else if (k_r != 4'h0) begin
            k_nxt = k_r - 4'h1;
          end else begin
            tck_nxt = 1'b0;
          end
          done = (pos_r != 9'h000) && y_nxt == 4'h0 && k_nxt == 4'h0 &&
                 !tck_nxt;
          if (done) begin
            pos_nxt = 9'h000;
            if (prot_nxt != `PROT_BLOCK) begin
              st_nxt = link_pkg::T_PPS_TX; // R14
            end else begin
              st_nxt = link_pkg::T_IDLE;
              up_nxt = 1'b1;
            end
          end
        end
      end
      link_pkg::T_PPS_TX: begin
        if (sp_ok && (pos_r != 9'h000 || tmr_r >= `BGT_ETU)) begin
          tmr_nxt = 16'h0000;
          t2c_stb_nxt = 1'b1;
          t2c_data_nxt = pps; // R14
          pos_nxt = pos_r + 9'h001;
          if (pos_r == `PPS_LAST) begin
            pos_nxt = 9'h000;
            st_nxt = link_pkg::T_PPS_RX;
          end
        end
      end
      link_pkg::T_PPS_RX: begin
        if (link.c2t_stb) begin
          tmr_nxt = 16'h0000;
          pos_nxt = pos_r + 9'h001;
          if (pos_r == `PPS_LAST) begin
            pos_nxt = 9'h000;
            st_nxt = link_pkg::T_IDLE;
            up_nxt = 1'b1;
          end
        end
      end
      link_pkg::T_IDLE: begin
        if (tx_valid && rdy_r) begin
          tmr_nxt = 16'h0000;
          t2c_stb_nxt = 1'b1;
          t2c_data_nxt = tx_data;
          lrc_nxt = tx_data;
          last_nxt = tx_last;
          st_nxt = link_pkg::T_TX;
        end else begin
          rdy_nxt = (tmr_r >= `BGT_ETU); // R12
        end
      end
      link_pkg::T_TX: begin
        if (last_r) begin
          if (sp_ok) begin
            t2c_stb_nxt = 1'b1;
            t2c_data_nxt = lrc_r;
            tmr_nxt = 16'h0000;
            pos_nxt = 9'h000;
            st_nxt = link_pkg::T_RX;
          end
        end else if (tx_valid && rdy_r) begin
          tmr_nxt = 16'h0000;
          t2c_stb_nxt = 1'b1;
          t2c_data_nxt = tx_data;
          lrc_nxt = lrc_r ^ tx_data;
          last_nxt = tx_last;
        end else begin
          rdy_nxt = (tmr_r >= `CHAR_ETU - 16'h0001);
        end
      end
      link_pkg::T_RX: begin
        if (link.c2t_stb) begin
          tmr_nxt = 16'h0000;
          pos_nxt = pos_r + 9'h001;
          lrc_nxt = (pos_r == 9'h000) ? d : lrc_r ^ d;
          rxs_nxt = 1'b1;
          rxd_nxt = d;
          if (pos_r == 9'h002) begin
            len_nxt = d;
          end
          if (pos_r >= 9'h003 && pos_r == 9'h003 + {1'b0, len_r}) begin
            rxe_nxt = 1'b1;
            ok_nxt = ((lrc_r ^ d) == 8'h00);
            pos_nxt = 9'h000;
            st_nxt = link_pkg::T_IDLE;
          end
        end else if ((pos_r == 9'h000 && tmr_r > bwt) ||
                     (pos_r != 9'h000 && tmr_r > cwt)) begin
          to_nxt = 1'b1;
          pos_nxt = 9'h000;
          st_nxt = link_pkg::T_IDLE;
        end
      end
      default: begin
        st_nxt = link_pkg::T_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= link_pkg::T_ATR;
      tmr_r <= 16'h0000;
      pos_r <= 9'h000;
      len_r <= 8'h00;
      lrc_r <= 8'h00;
      ifsc_r <= `IFS_DEF;
      y_r <= 4'h0;
      k_r <= 4'h0;
      prot_r <= 4'h0;
      cwi_r <= 4'h0;
      bwi_r <= 4'h0;
      lvl_r <= 2'h0;
      tck_r <= 1'b0;
      last_r <= 1'b0;
      rdy_r <= 1'b0;
      up_r <= 1'b0;
      t2c_stb_r <= 1'b0;
      t2c_data_r <= 8'h00;
      rxs_r <= 1'b0;
      rxd_r <= 8'h00;
      rxe_r <= 1'b0;
      ok_r <= 1'b0;
      to_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      pos_r <= pos_nxt;
      len_r <= len_nxt;
      lrc_r <= lrc_nxt;
      ifsc_r <= ifsc_nxt;
      y_r <= y_nxt;
      k_r <= k_nxt;
      prot_r <= prot_nxt;
      cwi_r <= cwi_nxt;
      bwi_r <= bwi_nxt;
      lvl_r <= lvl_nxt;
      tck_r <= tck_nxt;
      last_r <= last_nxt;
      rdy_r <= rdy_nxt;
      up_r <= up_nxt;
      t2c_stb_r <= t2c_stb_nxt;
      t2c_data_r <= t2c_data_nxt;
      rxs_r <= rxs_nxt;
      rxd_r <= rxd_nxt;
      rxe_r <= rxe_nxt;
      ok_r <= ok_nxt;
      to_r <= to_nxt;
    end
  end

  assign link.t2c_stb = t2c_stb_r;
  assign link.t2c_data = t2c_data_r;
  assign tx_ready = rdy_r;
  assign rx_stb = rxs_r;
  assign rx_data = rxd_r;
  assign rx_end = rxe_r;
  assign rx_ok = ok_r;
  assign rx_timeout = to_r;
  assign ifsc = ifsc_r;
  assign cwi = cwi_r;
  assign bwi = bwi_r;
  assign link_up = up_r;
endmodule

// ---- verification/link_sva.sv ----
`timescale 1ns/1ps
module link_sva #(
  parameter logic [15:0] BWT_ETU = 16'h0100
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic t2c_stb,
  input wire logic [7:0] t2c_data,
  input wire logic c2t_stb,
  input wire logic [7:0] c2t_data
);
  localparam int BWT_CYC = 4 * BWT_ETU;
  logic [15:0] ct_r, ct_nxt, cc_r, cc_nxt;
  // Cycles since the last character of each side, saturating.
  always_comb begin
    ct_nxt = t2c_stb ? 16'h0000 : ct_r + {15'h0000, ct_r != 16'hFFFF};
    cc_nxt = c2t_stb ? 16'h0000 : cc_r + {15'h0000, cc_r != 16'hFFFF};
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ct_r <= 16'hFFFF;
      cc_r <= 16'hFFFF;
    end else begin
      ct_r <= ct_nxt;
      cc_r <= cc_nxt;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence atr_first_s;
    $rose(rst_b) ##[1:8] (c2t_stb && c2t_data == 8'h3B);
  endsequence
  half_duplex_a: assert property (!(t2c_stb && c2t_stb))
    else $error("both sides strobed at once");
  card_spacing_a: assert property (c2t_stb |-> cc_r >= 16'd47)
    else $error("card characters too close");
  card_guard_a: assert property (c2t_stb && cc_r > ct_r |-> ct_r >= 16'd88)
    else $error("card reply inside guard time");
  card_reply_a: assert property (!(cc_r > ct_r && ct_r == BWT_CYC))
    else $error("card silent past waiting time");
  term_gap_a: assert property (t2c_stb && ct_r > cc_r |-> cc_r >= 16'd87)
    else $error("terminal block started too early");
  atr_ifsc_a: assert property (atr_first_s |-> ##192 c2t_data == 8'h20)
    else $error("field size byte wrong");
  atr_cwi_a: assert property (atr_first_s |-> ##240 c2t_data[3:0] <= 4'h5)
    else $error("character waiting index out of range");
  atr_tc3_a: assert property (atr_first_s |-> ##288 c2t_data == 8'h00)
    else $error("check type byte not zero");
endmodule

// ---- verification/block_protocol_timing_ifs_tb.sv ----
`timescale 1ns/1ps
module block_protocol_timing_ifs_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic tx_last = 1'b0;
  logic resp_avail = 1'b0;
  logic [15:0] resp_len = 16'h0000;
  logic [7:0] idx = 8'h00;
  logic [7:0] last_cmd = 8'h00;
  logic cmd_stb, cmd_end, cmd_ok, resp_take, tx_ready, rx_stb, rx_end;
  logic link_up, rx_ok;
  logic [7:0] cmd_data, ifsd, rx_data, ifsc;
  logic [3:0] cwi;
  logic [7:0] rxq[$];
  int nblk = 0;
  int failures = 0;
  int tests_run = 0;
  card_link_if card_link_if_inst ();
  always #50 clk = ~clk;
  card_end #(.BWT_ETU(16'h0100)) card_end_inst (.clk(clk), .rst_b(rst_b),
    .link(card_link_if_inst), .cmd_stb(cmd_stb), .cmd_data(cmd_data),
    .cmd_end(cmd_end), .cmd_ok(cmd_ok), .resp_avail(resp_avail),
    .resp_len(resp_len), .resp_data(idx), .resp_take(resp_take),
    .ifsd(ifsd));
  term_end #(.BWT_UNIT(16'h0010)) term_end_inst (.clk(clk), .rst_b(rst_b),
    .link(card_link_if_inst), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready), .rx_stb(rx_stb),
    .rx_data(rx_data), .rx_end(rx_end), .rx_ok(rx_ok), .rx_timeout(),
    .ifsc(ifsc), .cwi(cwi), .bwi(), .link_up(link_up));
  link_sva #(.BWT_ETU(16'h0100)) link_sva_inst (.clk(clk), .rst_b(rst_b),
    .t2c_stb(card_link_if_inst.t2c_stb),
    .t2c_data(card_link_if_inst.t2c_data),
    .c2t_stb(card_link_if_inst.c2t_stb),
    .c2t_data(card_link_if_inst.c2t_data));
  // Collects card blocks and serves response bytes in take order.
  always @(posedge clk) begin
    if (rx_stb) rxq.push_back(rx_data);
    if (rx_end) nblk <= nblk + 1;
    if (cmd_stb) last_cmd <= cmd_data;
    if (resp_take) begin
      idx <= idx + 8'h01;
      if (idx + 8'h01 == resp_len[7:0]) resp_avail <= 1'b0;
    end
  end
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask
  task report_and_stop;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic xfer(input logic [7:0] b[$]);
    int n, k;
    n = 0;
    k = nblk;
    rxq = {};
    for (int i = 0; i < b.size(); i++) begin
      tx_data <= b[i];
      tx_valid <= 1'b1;
      tx_last <= (i == b.size() - 1);
      do begin
        @(posedge clk);
        n++;
      end while (!tx_ready && n < 20000);
    end
    tx_valid <= 1'b0;
    while (nblk == k && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000) begin
      failures++;
      report_and_stop;
    end
    chk("rxok", {7'h00, rx_ok}, 8'h01);
  endtask
  task automatic cmd(input logic [7:0] pcb, input logic av);
    resp_len <= 16'h0028;
    idx <= 8'h00;
    resp_avail <= av;
    xfer({8'h00, pcb, 8'h01, 8'hA5});
  endtask
  task automatic restart;
    int n;
    n = 0;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    while (!link_up && n < 9000) begin
      @(posedge clk);
      n++;
    end
    if (!link_up) begin
      failures++;
      report_and_stop;
    end
    chk("ifsd", ifsd, 8'h20);
  endtask
  task automatic t_chain;
    chk("ifsc", ifsc, 8'h20);
    chk("cwi", {4'h0, cwi}, 8'h05);
    cmd(8'h00, 1'b1);
    chk("pcb1", rxq[1], 8'h20);
    chk("len1", rxq[2], 8'h20);
    chk("cmd", last_cmd, 8'hA5);
    xfer({8'h00, 8'h90, 8'h00});
    chk("pcb2", rxq[1], 8'h40);
    chk("len2", rxq[2], 8'h08);
    chk("byte", rxq[3], 8'h20);
    $display("chain test done");
  endtask
  task automatic t_ifs;
    xfer({8'h00, 8'hC1, 8'h01, 8'hFF});
    chk("rpcb", rxq[1], 8'h92);
    chk("rlen", rxq[2], 8'h00);
    chk("ifsd", ifsd, 8'h20);
    xfer({8'h00, 8'hC1, 8'h01, 8'hFE});
    chk("spcb", rxq[1], 8'hE1);
    chk("sinf", rxq[3], 8'hFE);
    chk("ifsd", ifsd, 8'hFE);
    cmd(8'h40, 1'b1);
    chk("len", rxq[2], 8'h28);
    chk("ok", {7'h00, cmd_ok}, 8'h01);
    $display("size test done");
  endtask
  task automatic t_wtx;
    cmd(8'h00, 1'b0);
    chk("wpcb", rxq[1], 8'hC3);
    chk("winf", rxq[3], 8'h01);
    resp_avail <= 1'b1;
    xfer({8'h00, 8'hE3, 8'h01, 8'h01});
    chk("len", rxq[2], 8'h28);
    restart;
    cmd(8'h00, 1'b1);
    chk("len", rxq[2], 8'h20);
    $display("extension test done");
  endtask
  initial begin
    restart;
    t_chain;
    t_ifs;
    t_wtx;
    report_and_stop;
  end
endmodule
